// ### rtl/cabe_alu.v
`timescale 1ns/100ps
`include "cabe_defines.vh"
module cabe_alu (
   input  wire [2:0] fn,     // Function select
   input  wire [7:0] a,      // Destination operand
   input  wire [7:0] b,      // Source operand
   input  wire       cin,    // Carry flag in
   input  wire       zin,    // Zero flag in
   input  wire       use_c,  // Include carry, chain zero on subtract
   output reg  [7:0] res,    // Result byte
   output reg        c,      // Carry out
   output reg        z,      // Zero out
   output reg        n,      // Negative out
   output reg        v,      // Overflow out
   output reg        h       // Half carry out
);

   reg [8:0] t;

   always @* begin
      t = 9'h000;
      c = 1'b0;
      h = 1'b0;
      v = 1'b0;
      case (fn)
         `CABE_FN_ADD: begin
            t = {1'b0, a} + {1'b0, b} + {8'h00, use_c & cin};
            c = t[8];
            h = (a[3] & b[3]) | (b[3] & ~t[3]) | (~t[3] & a[3]);
            v = (a[7] & b[7] & ~t[7]) | (~a[7] & ~b[7] & t[7]);
         end
         `CABE_FN_SUB: begin
            t = {1'b0, a} - {1'b0, b} - {8'h00, use_c & cin};
            c = t[8];
            h = (~a[3] & b[3]) | (b[3] & t[3]) | (t[3] & ~a[3]);
            v = (a[7] & ~b[7] & ~t[7]) | (~a[7] & b[7] & t[7]);
         end
         `CABE_FN_AND: t = {1'b0, a & b};
         `CABE_FN_OR:  t = {1'b0, a | b};
         `CABE_FN_EOR: t = {1'b0, a ^ b};
         default:      t = 9'h000;
      endcase
      res = t[7:0];
      n   = t[7];
      // In subtract with carry the zero flag only stays set, so multi-byte compares chain
      z   = (fn == `CABE_FN_SUB && use_c) ? (zin & (t[7:0] == 8'h00)) : (t[7:0] == 8'h00);
   end

endmodule

// ### rtl/cabe_defines.vh
`ifndef CABE_DEFINES_VH
`define CABE_DEFINES_VH

// APB register offsets (byte addresses)
`define CABE_OFS_INSTR   12'h000
`define CABE_OFS_STAT    12'h004
`define CABE_OFS_PC      12'h008
`define CABE_OFS_RET     12'h00C
`define CABE_GPR_BASE    12'h080
`define CABE_IO_BASE     12'h100

// Instruction word fields
`define CABE_OP_MSB      4
`define CABE_OP_LSB      0
`define CABE_RD_MSB      9
`define CABE_RD_LSB      5
`define CABE_RR_MSB      14
`define CABE_RR_LSB      10
`define CABE_K_MSB       22
`define CABE_K_LSB       15
`define CABE_POL_BIT     23
`define CABE_TWO_BIT     24
`define CABE_IOA_MSB     30
`define CABE_IOA_LSB     25

// Operation codes
`define CABE_OP_ADD      5'h00
`define CABE_OP_ADC      5'h01
`define CABE_OP_SUB      5'h02
`define CABE_OP_SUBI     5'h03
`define CABE_OP_SBC      5'h04
`define CABE_OP_SBCK     5'h05
`define CABE_OP_AND      5'h06
`define CABE_OP_ANDK     5'h07
`define CABE_OP_OR       5'h08
`define CABE_OP_ORK      5'h09
`define CABE_OP_EOR      5'h0A
`define CABE_OP_MCLR     5'h0B
`define CABE_OP_TEST     5'h0C
`define CABE_OP_CMP      5'h0D
`define CABE_OP_CMPC     5'h0E
`define CABE_OP_CMPK     5'h0F
`define CABE_OP_WADD     5'h10
`define CABE_OP_WSUB     5'h11
`define CABE_OP_MULU     5'h12
`define CABE_OP_MULS     5'h13
`define CABE_OP_MIXED_SIGN_PRODUCT    5'h14
`define CABE_OP_FMULU    5'h15
`define CABE_OP_FMULS    5'h16
`define CABE_OP_FRACTIONAL_MIXED_PRODUCT   5'h17
`define CABE_OP_PJMP     5'h18
`define CABE_OP_PCALL    5'h19
`define CABE_OP_EQSKIP   5'h1A
`define CABE_OP_RBSKIP   5'h1B
`define CABE_OP_IOSKIP   5'h1C
`define CABE_OP_BRANCH   5'h1D
`define CABE_OP_IOSET    5'h1E
`define CABE_OP_IOCLR    5'h1F

// ALU functions
`define CABE_FN_ADD      3'h0
`define CABE_FN_SUB      3'h1
`define CABE_FN_AND      3'h2
`define CABE_FN_OR       3'h3
`define CABE_FN_EOR      3'h4

// Status register bits and update masks
`define CABE_FLG_C       0
`define CABE_FLG_Z       1
`define CABE_FLG_N       2
`define CABE_FLG_V       3
`define CABE_FLG_S       4
`define CABE_FLG_H       5
`define CABE_FLG_I       7
`define CABE_FM_ARITH    8'h3F
`define CABE_FM_LOGIC    8'h1E
`define CABE_FM_WORD     8'h1F
`define CABE_FM_MUL      8'h03
`define CABE_STATUS_REGISTER_RST    8'h00

// STAT register fields
`define CABE_STAT_BUSY   8
`define CABE_STAT_REF    9

// Cycle counts
`define CABE_CYC_1       2'h1
`define CABE_CYC_2       2'h2
`define CABE_CYC_3       2'h3

// I/O space
`define CABE_IO_MAX      6'h1F
`define CABE_W1C_IDX     5
`define CABE_W1C_MASK    8'hC0
`define CABE_MULTI_MAX   5'h01

`endif

// ### rtl/cabe_exec.v
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
`include "cabe_defines.vh"
// Operation
// - Add with carry sums two registers and carry, sets Z C N V H, one cycle
// - Subtract-with-carry constant: rd minus K minus carry, Z C N V H, one cycle
// - Word add/subtract constant on a register pair, sets Z C N V S, two cycles
// - AND, OR with register or constant, EOR with register, set only Z N V S, one cycle
// - Bit mask clear ANDs rd with 0xFF minus constant, sets Z N V
// - Zero-sign test ANDs register with itself, value kept, sets Z N V
// - Unsigned, signed, mixed multiply put product in pair one:zero, Z C, two cycles
// - Fractional multiplies shift product left one bit before storing, Z C
// - Pointer jump loads PC from pointer pair, two cycles, no flag change
// - Pointer call loads PC from pointer pair, three cycles, flags untouched
// - Equal compare skip skips next instruction on match, 1/2/3 cycles, no flags
// - Register bit skip on cleared bit, or set bit for complementary form
// - I/O bit skip on cleared or set I/O bit, 1/2/3 cycles, no flags
// - Compares subtract without storing, update Z N V C H, one cycle
// - Status-bit branch sets PC to PC plus offset plus one, 1/2 cycles
// - Signed greater-or-equal branch taken when N xor V equals zero
// - Signed less-than branch taken when N xor V equals one
// - Unsigned branches test carry, decoded like carry clear and carry set
// - Interrupt-enable branches test I flag, one cycle untaken, two taken
// - Flags clear on write of one; I/O bit set/clear rewrite whole register
// - I/O bit set and clear accepted only for addresses 0x00 to 0x1F
module cabe_exec (
   input  wire        pclk,      // APB clock
   input  wire        presetn,   // Asynchronous reset, active low
   input  wire [11:0] paddr,     // APB byte address
   input  wire        psel,      // APB select
   input  wire        penable,   // APB access phase
   input  wire        pwrite,    // APB write
   input  wire [31:0] pwdata,    // APB write data
   input  wire [7:0]  io_event,  // Flag set events from peripherals
   output wire [31:0] prdata,    // APB read data
   output wire        pready,    // APB ready
   output wire        pslverr,   // APB error
   output wire        exec_busy  // Instruction in progress
);

   localparam ST_IDLE = 2'b01;
   localparam ST_EXEC = 2'b10;

   reg  [1:0]  st_r;
   reg  [1:0]  cnt_r;
   reg  [31:0] instr_r;
   reg  [15:0] pc_r;
   reg  [15:0] ret_pc_r;
   reg  [7:0]  status_register_r;
   reg         refused_r;
   reg  [7:0]  gpr_r [0:31];
   reg  [31:0] prdata_r;
   reg         pready_r;
   reg         pslverr_r;
   reg  [7:0]  io_ev_m_r;
   reg  [7:0]  io_ev_s_r;
   wire [255:0] io_all;

   wire        busy;
   wire        setup;
   wire        acc_wr;
   wire        hit_gpr;
   wire        hit_io;
   wire        hit_reg;
   wire        mapped;
   wire [4:0]  aidx;
   wire [4:0]  op;
   wire [4:0]  rd;
   wire [4:0]  rr;
   wire [7:0]  k;
   wire [5:0]  ioa;
   wire [4:0]  pb;
   wire [4:0]  pb1;
   wire [7:0]  rd_v;
   wire [7:0]  rr_v;
   wire [7:0]  io_v;
   wire [15:0] pw;
   wire [15:0] ptr;
   wire [7:0]  alu_res;
   wire        alu_c;
   wire        alu_z;
   wire        alu_n;
   wire        alu_v;
   wire        alu_h;
   wire [15:0] prod;
   wire        mul_c;
   wire        mul_z;
   wire        commit;
   wire        start;
   wire        apb_io_we;
   wire        io_we;
   wire [4:0]  io_widx;
   wire [7:0]  io_wd;

   reg  [2:0]  alu_fn;
   reg  [7:0]  alu_b;
   reg         alu_usec;
   reg         res_we;
   reg         word_we;
   reg         mul_we;
   reg         mul_as;
   reg         mul_bs;
   reg         mul_fr;
   reg  [7:0]  flg_mask;
   reg  [7:0]  flg_val;
   reg  [15:0] pc_nxt;
   reg  [1:0]  cyc;
   reg         cmd_io_we;
   reg  [7:0]  cmd_io_wd;
   reg         refuse;
   reg         call;
   reg         cond;
   reg  [16:0] wsum;
   reg  [31:0] rd_mux;

   assign busy      = st_r[1];
   assign exec_busy = st_r[1];
   assign prdata    = prdata_r;
   assign pready    = pready_r;
   assign pslverr   = pslverr_r;

   assign op   = instr_r[`CABE_OP_MSB:`CABE_OP_LSB];
   assign rd   = instr_r[`CABE_RD_MSB:`CABE_RD_LSB];
   assign rr   = instr_r[`CABE_RR_MSB:`CABE_RR_LSB];
   assign k    = instr_r[`CABE_K_MSB:`CABE_K_LSB];
   assign ioa  = instr_r[`CABE_IOA_MSB:`CABE_IOA_LSB];
   assign pb   = {rd[4:1], 1'b0};
   assign pb1  = {rd[4:1], 1'b1};
   assign rd_v = gpr_r[rd];
   assign rr_v = gpr_r[rr];
   assign pw   = {gpr_r[pb1], gpr_r[pb]};
   assign ptr  = {gpr_r[5'h1F], gpr_r[5'h1E]};
   // Addresses above the I/O file read as zero for the skip tests
   assign io_v = (ioa > `CABE_IO_MAX) ? 8'h00 : io_all[ioa[4:0]*8 +: 8];

   cabe_alu u_alu (
      .fn    (alu_fn),
      .a     (rd_v),
      .b     (alu_b),
      .cin   (status_register_r[`CABE_FLG_C]),
      .zin   (status_register_r[`CABE_FLG_Z]),
      .use_c (alu_usec),
      .res   (alu_res),
      .c     (alu_c),
      .z     (alu_z),
      .n     (alu_n),
      .v     (alu_v),
      .h     (alu_h)
   );

   cabe_mul u_mul (
      .a     (rd_v),
      .b     (rr_v),
      .a_sgn (mul_as),
      .b_sgn (mul_bs),
      .frac  (mul_fr),
      .prod  (prod),
      .c     (mul_c),
      .z     (mul_z)
   );

   always @* begin
      alu_fn    = `CABE_FN_ADD;
      alu_b     = rr_v;
      alu_usec  = 1'b0;
      res_we    = 1'b0;
      word_we   = 1'b0;
      mul_we    = 1'b0;
      mul_as    = 1'b0;
      mul_bs    = 1'b0;
      mul_fr    = 1'b0;
      flg_mask  = 8'h00;
      flg_val   = {2'b00, alu_h, alu_n ^ alu_v, alu_v, alu_n, alu_z, alu_c};
      pc_nxt    = pc_r + 16'h0001;
      cyc       = `CABE_CYC_1;
      cmd_io_we = 1'b0;
      cmd_io_wd = io_v;
      refuse    = 1'b0;
      call      = 1'b0;
      cond      = 1'b0;
      wsum      = {1'b0, pw} + {11'h000, k[5:0]};
      case (op)
         `CABE_OP_ADD, `CABE_OP_ADC: begin
            alu_usec = (op == `CABE_OP_ADC);
            res_we   = 1'b1;
            flg_mask = `CABE_FM_ARITH;
         end
         `CABE_OP_SUB, `CABE_OP_SUBI, `CABE_OP_SBC, `CABE_OP_SBCK: begin
            alu_fn   = `CABE_FN_SUB;
            alu_b    = (op == `CABE_OP_SUBI || op == `CABE_OP_SBCK) ? k : rr_v;
            alu_usec = (op == `CABE_OP_SBC || op == `CABE_OP_SBCK);
            res_we   = 1'b1;
            flg_mask = `CABE_FM_ARITH;
         end
         `CABE_OP_CMP, `CABE_OP_CMPC, `CABE_OP_CMPK: begin
            alu_fn   = `CABE_FN_SUB;
            alu_b    = (op == `CABE_OP_CMPK) ? k : rr_v;
            alu_usec = (op == `CABE_OP_CMPC);
            flg_mask = `CABE_FM_ARITH;
         end
         `CABE_OP_AND, `CABE_OP_ANDK, `CABE_OP_OR, `CABE_OP_ORK, `CABE_OP_EOR: begin
            alu_fn   = (op == `CABE_OP_EOR) ? `CABE_FN_EOR :
                       (op == `CABE_OP_OR || op == `CABE_OP_ORK) ? `CABE_FN_OR : `CABE_FN_AND;
            alu_b    = (op == `CABE_OP_ANDK || op == `CABE_OP_ORK) ? k : rr_v;
            res_we   = 1'b1;
            flg_mask = `CABE_FM_LOGIC;
         end
         `CABE_OP_MCLR: begin
            alu_fn   = `CABE_FN_AND;
            alu_b    = 8'hFF - k;
            res_we   = 1'b1;
            flg_mask = `CABE_FM_LOGIC;
         end
         `CABE_OP_TEST: begin
            alu_fn   = `CABE_FN_AND;
            alu_b    = rd_v;
            res_we   = 1'b1;
            flg_mask = `CABE_FM_LOGIC;
         end
         `CABE_OP_WADD, `CABE_OP_WSUB: begin
            if (op == `CABE_OP_WSUB) begin
               wsum = {1'b0, pw} - {11'h000, k[5:0]};
            end
            word_we  = 1'b1;
            cyc      = `CABE_CYC_2;
            flg_mask = `CABE_FM_WORD;
            flg_val[`CABE_FLG_C] = wsum[16];
            flg_val[`CABE_FLG_Z] = (wsum[15:0] == 16'h0000);
            flg_val[`CABE_FLG_N] = wsum[15];
            flg_val[`CABE_FLG_V] = (op == `CABE_OP_WSUB) ? (pw[15] & ~wsum[15]) :
                                                             (~pw[15] & wsum[15]);
            flg_val[`CABE_FLG_S] = flg_val[`CABE_FLG_N] ^ flg_val[`CABE_FLG_V];
         end
         `CABE_OP_MULU, `CABE_OP_MULS, `CABE_OP_MIXED_SIGN_PRODUCT,
         `CABE_OP_FMULU, `CABE_OP_FMULS, `CABE_OP_FRACTIONAL_MIXED_PRODUCT: begin
            mul_as   = (op == `CABE_OP_MULS || op == `CABE_OP_MIXED_SIGN_PRODUCT ||
                        op == `CABE_OP_FMULS || op == `CABE_OP_FRACTIONAL_MIXED_PRODUCT);
            mul_bs   = (op == `CABE_OP_MULS || op == `CABE_OP_FMULS);
            mul_fr   = (op >= `CABE_OP_FMULU);
            mul_we   = 1'b1;
            cyc      = `CABE_CYC_2;
            flg_mask = `CABE_FM_MUL;
            flg_val  = {6'h00, mul_z, mul_c};
         end
         `CABE_OP_PJMP: begin
            pc_nxt = ptr;
            cyc    = `CABE_CYC_2;
         end
         `CABE_OP_PCALL: begin
            pc_nxt = ptr;
            call   = 1'b1;
            cyc    = `CABE_CYC_3;
         end
         `CABE_OP_EQSKIP, `CABE_OP_RBSKIP, `CABE_OP_IOSKIP: begin
            if (op == `CABE_OP_EQSKIP) begin
               cond = (rd_v == rr_v);
            end else if (op == `CABE_OP_RBSKIP) begin
               cond = (rd_v[k[2:0]] == instr_r[`CABE_POL_BIT]);
            end else begin
               cond = (io_v[k[2:0]] == instr_r[`CABE_POL_BIT]);
            end
            if (cond) begin
               // Skipped length is told by software; the core holds no program memory
               pc_nxt = pc_r + (instr_r[`CABE_TWO_BIT] ? 16'h0003 : 16'h0002);
               cyc    = instr_r[`CABE_TWO_BIT] ? `CABE_CYC_3 : `CABE_CYC_2;
            end
         end
         `CABE_OP_BRANCH: begin
            // Signed select reads N xor V live, so a stale S bit cannot mislead it
            cond = (rr[2:0] == `CABE_FLG_S) ?
                   (status_register_r[`CABE_FLG_N] ^ status_register_r[`CABE_FLG_V]) :
                   status_register_r[rr[2:0]];
            if (cond == instr_r[`CABE_POL_BIT]) begin
               pc_nxt = pc_r + {{9{k[6]}}, k[6:0]} + 16'h0001;
               cyc    = `CABE_CYC_2;
            end
         end
         `CABE_OP_IOSET, `CABE_OP_IOCLR: begin
            if (ioa > `CABE_IO_MAX) begin
               refuse = 1'b1;
            end else begin
               cmd_io_we = 1'b1;
               cyc       = `CABE_CYC_2;
               // Whole byte written back, so set flags read here get cleared
               cmd_io_wd = (op == `CABE_OP_IOSET) ? (io_v | (8'h01 << k[2:0])) :
                                                    (io_v & ~(8'h01 << k[2:0]));
            end
         end
         default: begin
            cyc = `CABE_CYC_1;
         end
      endcase
   end

   // APB decode
   assign setup   = psel & ~penable;
   assign acc_wr  = psel & penable & pready_r & pwrite & ~pslverr_r;
   assign aidx    = paddr[6:2];
   assign hit_gpr = (paddr[11:7] == `CABE_GPR_BASE >> 7);
   assign hit_io  = (paddr[11:7] == `CABE_IO_BASE >> 7);
   assign hit_reg = (paddr == `CABE_OFS_INSTR) || (paddr == `CABE_OFS_STAT) ||
                    (paddr == `CABE_OFS_PC) || (paddr == `CABE_OFS_RET);
   assign mapped  = (paddr[1:0] == 2'b00) && (hit_gpr || hit_io || hit_reg);

   always @* begin
      if (hit_gpr) begin
         rd_mux = {24'h000000, gpr_r[aidx]};
      end else if (hit_io) begin
         rd_mux = {24'h000000, io_all[aidx*8 +: 8]};
      end else begin
         case (paddr)
            `CABE_OFS_INSTR: rd_mux = instr_r;
            `CABE_OFS_STAT:  rd_mux = {22'h000000, refused_r, busy, status_register_r};
            `CABE_OFS_PC:    rd_mux = {16'h0000, pc_r};
            `CABE_OFS_RET:   rd_mux = {16'h0000, ret_pc_r};
            default:         rd_mux = 32'h00000000;
         endcase
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
      end else begin
         // Ready one cycle after setup; writes are refused while an instruction runs
         pready_r  <= setup;
         pslverr_r <= setup & (~mapped | (pwrite & busy));
         prdata_r  <= (setup & ~pwrite & mapped) ? rd_mux : 32'h00000000;
      end
   end

   assign start     = acc_wr & (paddr == `CABE_OFS_INSTR);
   assign commit    = busy & (cnt_r == cyc);
   assign apb_io_we = acc_wr & hit_io;
   assign io_we     = apb_io_we | (commit & cmd_io_we);
   assign io_widx   = apb_io_we ? aidx : ioa[4:0];
   assign io_wd     = apb_io_we ? pwdata[7:0] : cmd_io_wd;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_ev_m_r <= 8'h00;
         io_ev_s_r <= 8'h00;
      end else begin
         io_ev_m_r <= io_event;
         io_ev_s_r <= io_ev_m_r;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 32; g = g + 1) begin : io_e
         localparam [7:0] W1C = (g == `CABE_W1C_IDX) ? `CABE_W1C_MASK : 8'h00;
         reg [7:0] q_r;
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               q_r <= 8'h00;
            end else if (io_we && io_widx == g) begin
               // Flag bits clear on one, keep on zero; a new event wins
               q_r <= (io_wd & ~W1C) | (q_r & W1C & ~io_wd) | (io_ev_s_r & W1C);
            end else begin
               q_r <= q_r | (io_ev_s_r & W1C);
            end
         end
         assign io_all[g*8 +: 8] = q_r;
      end
   endgenerate

   integer i;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r      <= ST_IDLE;
         cnt_r     <= `CABE_CYC_1;
         instr_r   <= 32'h00000000;
         pc_r      <= 16'h0000;
         ret_pc_r  <= 16'h0000;
         status_register_r    <= `CABE_STATUS_REGISTER_RST;
         refused_r <= 1'b0;
         for (i = 0; i < 32; i = i + 1) begin
            gpr_r[i] <= 8'h00;
         end
      end else begin
         case (st_r)
            ST_IDLE: begin
               if (start) begin
                  instr_r   <= pwdata;
                  cnt_r     <= `CABE_CYC_1;
                  refused_r <= 1'b0;
                  st_r      <= ST_EXEC;
               end
               if (acc_wr && paddr == `CABE_OFS_STAT) begin
                  status_register_r <= pwdata[7:0];
               end
               if (acc_wr && paddr == `CABE_OFS_PC) begin
                  pc_r <= pwdata[15:0];
               end
               if (acc_wr && hit_gpr) begin
                  gpr_r[aidx] <= pwdata[7:0];
               end
            end
            ST_EXEC: begin
               cnt_r <= cnt_r + `CABE_CYC_1;
               // Results land in the last cycle of the instruction
               if (commit) begin
                  st_r      <= ST_IDLE;
                  pc_r      <= pc_nxt;
                  status_register_r    <= (status_register_r & ~flg_mask) | (flg_val & flg_mask);
                  refused_r <= refuse;
                  if (call) begin
                     ret_pc_r <= pc_r + 16'h0001;
                  end
                  if (res_we) begin
                     gpr_r[rd] <= alu_res;
                  end
                  if (word_we) begin
                     gpr_r[pb]  <= wsum[7:0];
                     gpr_r[pb1] <= wsum[15:8];
                  end
                  if (mul_we) begin
                     gpr_r[5'h00] <= prod[7:0];
                     gpr_r[5'h01] <= prod[15:8];
                  end
               end
            end
            default: begin
               st_r <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

// ### rtl/cabe_mul.v
`timescale 1ns/100ps
module cabe_mul (
   input  wire [7:0]  a,      // Multiplicand
   input  wire [7:0]  b,      // Multiplier
   input  wire        a_sgn,  // Treat a as signed
   input  wire        b_sgn,  // Treat b as signed
   input  wire        frac,   // Fractional form, product shifted left
   output wire [15:0] prod,   // Stored product
   output wire        c,      // Carry flag result
   output wire        z       // Zero flag result
);

   wire signed [8:0]  ax;
   wire signed [8:0]  bx;
   wire signed [17:0] p;
   wire        [15:0] raw;

   assign ax   = {a_sgn & a[7], a};
   assign bx   = {b_sgn & b[7], b};
   assign p    = ax * bx;
   assign raw  = p[15:0];
   // Carry takes the top bit before the fractional shift drops it
   assign c    = raw[15];
   assign prod = frac ? {raw[14:0], 1'b0} : raw;
   assign z    = (prod == 16'h0000);

endmodule

// ### testbench/cabe_exec_monitor.sv
`timescale 1ns/100ps
module cabe_exec_monitor (
   input wire logic        pclk,      // Clock
   input wire logic        presetn,   // Reset, active low
   input wire logic [11:0] paddr,     // Address
   input wire logic        psel,      // Select
   input wire logic        penable,   // Access phase
   input wire logic        pwrite,    // Write
   input wire logic [31:0] pwdata,    // Write data
   input wire logic        pready,    // Ready
   input wire logic        pslverr,   // Error
   input wire logic        exec_busy  // Busy
);
   wire       go = psel && penable && pready && !pslverr && pwrite && paddr == 12'h000;
   wire [4:0] op = pwdata[4:0];
   wire       io = go && op[4:1] == 4'hF;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_single_cycle_ops: assert property (
      go && op <= 5'h0F |=> exec_busy ##1 !exec_busy)
      else $error("one-cycle op length wrong");
   a_two_cycle_ops: assert property (
      go && op[4:3] == 2'h2 |=> exec_busy[*2] ##1 !exec_busy)
      else $error("two-cycle op length wrong");
   a_call_three: assert property (
      go && op == 5'h19 |=> exec_busy[*3] ##1 !exec_busy)
      else $error("call length wrong");
   a_skip_bound: assert property (
      go && op inside {[5'h1A:5'h1C]} |=> exec_busy ##[1:3] !exec_busy)
      else $error("skip length wrong");
   a_skip_short: assert property (
      go && op inside {[5'h1A:5'h1C]} && !pwdata[24] |=> ##2 !exec_busy)
      else $error("one-word skip too long");
   a_branch_bound: assert property (
      go && op == 5'h1D |=> exec_busy ##[1:2] !exec_busy)
      else $error("branch length wrong");
   a_io_in_range: assert property (
      io && pwdata[30:25] <= 6'h1F |=> exec_busy[*2] ##1 !exec_busy)
      else $error("bit set length wrong");
   a_io_refused: assert property (
      io && pwdata[30:25] > 6'h1F |=> exec_busy ##1 !exec_busy)
      else $error("refused bit set length wrong");
endmodule
bind cabe_exec cabe_exec_monitor mon (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .exec_busy(exec_busy));

// ### testbench/test_cpu_alu_branch_execute.sv
`timescale 1ns/100ps
module test_cpu_alu_branch_execute;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, exec_busy, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, lfsr;
   logic [7:0]  io_event, a, b, s;
   logic [15:0] e;
   logic [4:0]  ops [6] = '{5'h01, 5'h05, 5'h0F, 5'h07, 5'h0B, 5'h0C};
   int          errors, num_checks, cyc;
   cabe_exec dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .io_event(io_event),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .exec_busy(exec_busy));
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   function automatic logic [15:0] model(input logic [4:0] op, input logic [7:0] x, y, f);
      logic [8:0] r;
      logic       ad, lg, ci;
      ad = op == 5'h01;
      lg = op == 5'h07 || op == 5'h0B || op == 5'h0C;
      ci = (op != 5'h0F) & f[0];
      r = ad ? x + y + ci : op == 5'h07 ? x & y : op == 5'h0C ? x & x : lg ? x & ~y : x - y - ci;
      f[1] = r[7:0] == 8'h00 && (op != 5'h05 || f[1]);
      f[2] = r[7];
      f[3] = !lg && (ad ? x[7] == y[7] : x[7] != y[7]) && r[7] != x[7];
      f[4] = f[2] ^ f[3];
      if (!lg) begin
         f[0] = r[8];
         f[5] = ad ? x[3:0] + y[3:0] + ci > 15 : x[3:0] < y[3:0] + ci + 5'h00;
      end
      return {f, op == 5'h0F ? x : r[7:0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic run(input logic [31:0] i, input int c);
      apb(1'b1, 12'h000, i);
      #1;
      cyc = 0;
      while (exec_busy === 1'b1 && cyc < 9) begin
         @(posedge pclk);
         #1;
         cyc++;
      end
      chk(cyc, c);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Whole run is about a thousand cycles; this leaves ample margin
   initial begin
      #200000;
      errors++;
      tally_and_finish();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, io_event} = '0;
      lfsr = 32'h53C9C27F;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 0; k < 20; k++) begin
         a = 8'(rnd());
         b = 8'(rnd());
         s = 8'(rnd());
         apb(1'b1, 12'h0C0, {24'h0, a});
         apb(1'b1, 12'h0C4, {24'h0, b});
         apb(1'b1, 12'h004, {24'h0, s});
         e = model(ops[k % 6], a, b, s);
         run({9'h000, b, 5'h11, 5'h10, ops[k % 6]}, 1);
         apb(1'b0, 12'h0C0, 0);
         chk(rd, {24'h0, e[7:0]});
         apb(1'b0, 12'h004, 0);
         chk(rd, {24'h0, e[15:8]});
      end
      $display("alu done");
      apb(1'b1, 12'h0E0, 32'hFF);
      apb(1'b1, 12'h0E4, 32'hFF);
      apb(1'b1, 12'h004, 32'h20);
      run({9'h000, 8'h01, 5'h00, 5'h18, 5'h10}, 2);
      apb(1'b0, 12'h0E4, 0);
      chk(rd, 0);
      apb(1'b0, 12'h004, 0);
      chk(rd, 32'h23);
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, 12'h0C0, k ? 32'h80 : 32'hFF);
         apb(1'b1, 12'h0C4, k ? 32'h80 : 32'hFF);
         run({17'h0, 5'h11, 5'h10, k ? 5'h16 : 5'h12}, 2);
         apb(1'b0, 12'h084, 0);
         chk(rd, k ? 32'h80 : 32'hFE);
      end
      $display("word and product done");
      apb(1'b1, 12'h0F8, 32'h34);
      apb(1'b1, 12'h0FC, 32'h12);
      apb(1'b0, 12'h004, 0);
      s = rd[7:0];
      run(32'h18, 2);
      run(32'h19, 3);
      apb(1'b0, 12'h00C, 0);
      chk(rd, 32'h1235);
      apb(1'b0, 12'h004, 0);
      chk(rd, {24'h0, s});
      apb(1'b0, 12'h008, 0);
      chk(rd, 32'h1234);
      for (int k = 0; k < 16; k++) begin
         s = 8'(rnd());
         b = 8'(rnd());
         apb(1'b1, 12'h004, {24'h0, s});
         apb(1'b1, 12'h008, 32'h50);
         a = {7'h0, (k[2:0] == 3'h4 ? s[2] ^ s[3] : s[k[2:0]]) == k[3]};
         e = a[0] ? {{9{b[6]}}, b[6:0]} : 16'h0000;
         run({8'h00, k[3], b, 2'h0, k[2:0], 10'h01D}, a[0] ? 2 : 1);
         apb(1'b0, 12'h008, 0);
         chk(rd, {16'h0, 16'h51 + e});
      end
      apb(1'b1, 12'h0C4, 32'h5B);
      for (int k = 0; k < 4; k++)
         run({7'h00, k[1], 13'h0008, k[0], 10'h23A}, k[0] ? 2 + k[1] : 1);
      run(32'h0001023B, 2);
      $display("branch and skip done");
      apb(1'b1, 12'h114, 32'h00);
      io_event <= 8'h80;
      @(posedge pclk);
      io_event <= 8'h00;
      repeat (4) @(posedge pclk);
      run({7'h05, 20'h0, 5'h1E}, 2);
      apb(1'b0, 12'h114, 0);
      chk(rd, 32'h01);
      run(32'h0A80001C, 2);
      run({7'h20, 20'h0, 5'h1E}, 1);
      apb(1'b0, 12'h004, 0);
      chk({31'h0, rd[9]}, 1);
      apb(1'b0, 12'h010, 0);
      chk({31'h0, er}, 1);
      $display("io done");
      tally_and_finish();
   end
endmodule
